// *** verilog/dioc_top.sv ***
// digital i/o channel control: port directions, interrupt sources, counters
`timescale 1ns/1ps
module dioc_top #(
  parameter int unsigned NUM_CH = 4
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  clk_en,
  input  wire logic                                  soft_reset,
  input  wire logic                                  cfg_wr,
  input  wire logic [1:0]                            cfg_ch,
  input  wire logic [3:0]                            control_code,
  input  wire logic                                  out_wr,
  input  wire logic [1:0]                            out_ch,
  input  wire logic [dioc_pkg::PORT_W-1:0]           out_data,
  input  wire logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_in,
  output logic      [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_out,
  output logic      [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_oe,
  output logic      [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] rd_data,
  input  wire logic                                  int_ctrl_wr,
  input  wire logic [3:0]                            int_ctrl,
  input  wire logic                                  ext_event_pin,
  input  wire logic                                  irq_clr,
  output logic                                       first_source_pending,
  output logic                                       second_source_pending,
  output logic                                       irq_out,
  input  wire logic                                  t0_load,
  input  wire dioc_pkg::dioc_t0_cmd_t                t0_cmd,
  input  wire logic                                  t0_stop,
  output logic      [dioc_pkg::CNT_W-1:0]            t0_count,
  output logic      [dioc_pkg::CNT_W-1:0]            t0_held,
  output logic                                       t0_running,
  output logic                                       t0_out,
  input  wire logic                                  casc_start,
  input  wire dioc_pkg::dioc_casc_div_t              casc_div,
  output logic                                       casc_out
);
  localparam int unsigned SRC2_CH = (NUM_CH > 1) ? 1 : 0;

  logic [NUM_CH-1:0][3:0]                  dir_q;
  logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] sync1_q;
  logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] sync2_q;
  logic [2:0]                              ev_q;
  logic [1:0]                              mode1_q;
  logic [1:0]                              mode2_q;
  logic                                    src1_evt;
  logic                                    src2_evt;
  logic                                    c2_term;
  logic [2:0]                              t0_mode_q;
  logic [dioc_pkg::CNT_W-1:0]              t0_init_q;
  logic [dioc_pkg::CNT_W-1:0]              c1_q;
  logic [dioc_pkg::CNT_W-1:0]              c2_q;
  logic [dioc_pkg::CNT_W-1:0]              c1_div_q;
  logic [dioc_pkg::CNT_W-1:0]              c2_div_q;
  logic                                    casc_run_q;
  logic                                    c1_tick;

  // direction codes; software reset wins over a same-cycle code write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_q <= {NUM_CH{dioc_pkg::DIR_RESET}};
    end else if (clk_en) begin
      if (soft_reset) begin
        dir_q <= {NUM_CH{dioc_pkg::DIR_RESET}};
      end else if (cfg_wr && (32'(cfg_ch) < NUM_CH)) begin
        dir_q[cfg_ch] <= control_code;
      end
    end
  end

  // per-channel group enables; output latches keep their value while a group is input,
  // so data written ahead of a direction change appears once the group turns output
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pin_oe[g]  <= '0;
        pin_out[g] <= '0;
        sync1_q[g] <= '0;
        sync2_q[g] <= '0;
        rd_data[g] <= '0;
      end else if (clk_en) begin
        pin_oe[g][dioc_pkg::A_LSB+:8]  <= {8{~dir_q[g][dioc_pkg::DIR_A_BIT]}};
        pin_oe[g][dioc_pkg::B_LSB+:8]  <= {8{~dir_q[g][dioc_pkg::DIR_B_BIT]}};
        pin_oe[g][dioc_pkg::CL_LSB+:4] <= {4{~dir_q[g][dioc_pkg::DIR_CL_BIT]}};
        pin_oe[g][dioc_pkg::CU_LSB+:4] <= {4{~dir_q[g][dioc_pkg::DIR_CU_BIT]}};
        if (out_wr && (32'(out_ch) == g)) begin
          pin_out[g] <= out_data;
        end
        sync1_q[g] <= pin_in[g];
        sync2_q[g] <= sync1_q[g];
        rd_data[g] <= sync2_q[g];
      end
    end
  end

  // interrupt mode fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode1_q <= dioc_pkg::MODE_RESET;
      mode2_q <= dioc_pkg::MODE_RESET;
    end else if (clk_en && int_ctrl_wr) begin
      mode1_q <= int_ctrl[dioc_pkg::IMODE1_LSB+:2];
      mode2_q <= int_ctrl[dioc_pkg::IMODE2_LSB+:2];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_q <= 3'h0;
    end else if (clk_en) begin
      ev_q <= {ev_q[1:0], ext_event_pin};
    end
  end

  // edges are taken between the second and third stage, never from the first
  function automatic logic src_edge(input logic [1:0] mode,
                                    input logic [dioc_pkg::PORT_W-1:0] now,
                                    input logic [dioc_pkg::PORT_W-1:0] was,
                                    input logic alt);
    logic r;
    r = 1'b0;
    unique case (mode)
      dioc_pkg::IMODE_OFF:  r = 1'b0;
      dioc_pkg::IMODE_C0:   r = now[dioc_pkg::C0_POS] & ~was[dioc_pkg::C0_POS];
      dioc_pkg::IMODE_C3C0: r = (now[dioc_pkg::C3_POS] & now[dioc_pkg::C0_POS])
                                & ~(was[dioc_pkg::C3_POS] & was[dioc_pkg::C0_POS]);
      dioc_pkg::IMODE_ALT:  r = alt;
    endcase
    return r;
  endfunction

  always_comb begin
    src1_evt = src_edge(mode1_q, sync2_q[0], rd_data[0], ev_q[1] & ~ev_q[2]);
    src2_evt = src_edge(mode2_q, sync2_q[SRC2_CH], rd_data[SRC2_CH], c2_term);
  end

  // sticky status; an event in the clearing cycle keeps its bit set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_source_pending  <= 1'b0;
      second_source_pending <= 1'b0;
      irq_out               <= 1'b0;
    end else if (clk_en) begin
      first_source_pending  <= src1_evt | (first_source_pending & ~irq_clr);
      second_source_pending <= src2_evt | (second_source_pending & ~irq_clr);
      irq_out               <= src1_evt | src2_evt
                               | ((first_source_pending | second_source_pending) & ~irq_clr);
    end
  end

  // counter zero: down counter; a load restarts it even while running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t0_count   <= dioc_pkg::CNT_RESET;
      t0_held    <= dioc_pkg::CNT_RESET;
      t0_init_q  <= dioc_pkg::CNT_RESET;
      t0_mode_q  <= 3'h0;
      t0_running <= 1'b0;
      t0_out     <= 1'b0;
    end else if (clk_en) begin
      if (t0_load) begin
        t0_mode_q  <= (t0_cmd.mode > dioc_pkg::T0_LAST) ? 3'h0 : t0_cmd.mode;
        t0_init_q  <= t0_cmd.init;
        t0_count   <= t0_cmd.init;
        t0_running <= 1'b1;
        t0_out     <= 1'b0;
      end else if (t0_stop) begin
        t0_running <= 1'b0;
        t0_held    <= t0_count;
      end else if (t0_running) begin
        if (t0_count != dioc_pkg::CNT_RESET) begin
          t0_count <= t0_count - dioc_pkg::CNT_ONE;
        end else if (t0_mode_q == dioc_pkg::T0_RATE || t0_mode_q == dioc_pkg::T0_SQUARE) begin
          t0_count <= t0_init_q;
          t0_out   <= (t0_mode_q == dioc_pkg::T0_SQUARE) ? ~t0_out : 1'b1;
        end else begin
          t0_running <= 1'b0;
          t0_out     <= 1'b1;
        end
      end
    end
  end

  // cascade: divisors 0 and 1 both divide by one, a plain limit of this counter
  always_comb begin
    c1_tick = casc_run_q && (c1_q <= dioc_pkg::CNT_ONE);
    c2_term = c1_tick && (c2_q <= dioc_pkg::CNT_ONE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c1_q       <= dioc_pkg::CNT_RESET;
      c2_q       <= dioc_pkg::CNT_RESET;
      c1_div_q   <= dioc_pkg::CNT_RESET;
      c2_div_q   <= dioc_pkg::CNT_RESET;
      casc_run_q <= 1'b0;
      casc_out   <= 1'b0;
    end else if (clk_en) begin
      if (casc_start) begin
        c1_div_q   <= casc_div.first;
        c2_div_q   <= casc_div.second;
        c1_q       <= casc_div.first;
        c2_q       <= casc_div.second;
        casc_run_q <= 1'b1;
        casc_out   <= 1'b0;
      end else if (casc_run_q) begin
        c1_q <= c1_tick ? c1_div_q : c1_q - dioc_pkg::CNT_ONE;
        if (c1_tick) begin
          c2_q <= c2_term ? c2_div_q : c2_q - dioc_pkg::CNT_ONE;
        end
        if (c2_term) begin
          casc_out <= ~casc_out;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_dir_soft;
    clk_en && soft_reset |=> dir_q == {NUM_CH{dioc_pkg::DIR_RESET}};
  endproperty
  a_dir_soft: assert property (p_dir_soft) else $error("soft reset left an output group");

  property p_dir_wr;
    clk_en && !soft_reset && cfg_wr && cfg_ch == 2'h0 |=> dir_q[0] == $past(control_code);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction code not stored");

  property p_oe_map;
    clk_en |=> pin_oe[0][dioc_pkg::A_LSB] == !$past(dir_q[0][dioc_pkg::DIR_A_BIT])
               && pin_oe[0][dioc_pkg::CU_LSB] == !$past(dir_q[0][dioc_pkg::DIR_CU_BIT]);
  endproperty
  a_oe_map: assert property (p_oe_map) else $error("enable does not follow direction");

  property p_mode_wr;
    clk_en && int_ctrl_wr |=> mode1_q == $past(int_ctrl[1:0]) && mode2_q == $past(int_ctrl[3:2]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("interrupt mode fields wrong");

  property p_mode_off;
    clk_en && mode1_q == dioc_pkg::IMODE_OFF && !first_source_pending |=> !first_source_pending;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled source raised event");

  property p_pend_set;
    clk_en && src2_evt |=> second_source_pending ##1 (second_source_pending || $past(irq_clr));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("status bit missed event");

  property p_pend_hold;
    first_source_pending && !irq_clr |=> first_source_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("status bit dropped early");

  property p_pend_clr;
    clk_en && irq_clr && !src1_evt && !src2_evt |=> !first_source_pending && !second_source_pending && !irq_out;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("clear did not clear");

  property p_t0_run;
    clk_en && t0_running && !t0_load && !t0_stop && t0_count > 16'h0002
      ##1 clk_en && !t0_load && !t0_stop |=> t0_count == $past(t0_count, 2) - 16'h0002;
  endproperty
  a_t0_run: assert property (p_t0_run) else $error("counter zero not counting");

  property p_t0_stop;
    clk_en && t0_stop && !t0_load |=> !t0_running && t0_held == $past(t0_count) && t0_count == t0_held;
  endproperty
  a_t0_stop: assert property (p_t0_stop) else $error("stop did not hold count");

  property p_t0_load;
    clk_en && t0_load |=> t0_running && t0_count == $past(t0_cmd.init);
  endproperty
  a_t0_load: assert property (p_t0_load) else $error("counter zero did not start");

  property p_casc;
    clk_en && casc_start && casc_div.first == 16'h0003 |=> casc_run_q ##1 clk_en ##1 clk_en |=> c1_q == 16'h0003;
  endproperty
  a_casc: assert property (p_casc) else $error("first divisor not reloaded");

  c_src1: cover property (clk_en && src1_evt ##1 first_source_pending);
  c_clr_race: cover property (clk_en && irq_clr && src2_evt);
  c_t0_stop: cover property (t0_running ##1 clk_en && t0_stop);
  c_casc_tog: cover property (casc_run_q && clk_en && c2_term);
endmodule

// *** verilog/dioc_pkg.sv ***
// shared constants and carrier types for the digital i/o channel block
package dioc_pkg;
  localparam int unsigned PORT_W      = 24;
  localparam int unsigned DIR_W       = 4;
  localparam int unsigned CNT_W       = 16;
  // direction code bit positions, 1 = input, 0 = output
  localparam int unsigned DIR_A_BIT   = 3;
  localparam int unsigned DIR_CU_BIT  = 2;
  localparam int unsigned DIR_B_BIT   = 1;
  localparam int unsigned DIR_CL_BIT  = 0;
  localparam logic [3:0]  DIR_RESET   = 4'hF;
  // byte and nibble lanes and port C bit positions inside a channel word
  localparam int unsigned A_LSB       = 0;
  localparam int unsigned B_LSB       = 8;
  localparam int unsigned CL_LSB      = 16;
  localparam int unsigned CU_LSB      = 20;
  localparam int unsigned C0_POS      = 16;
  localparam int unsigned C3_POS      = 19;
  // interrupt control code fields
  localparam int unsigned IMODE1_LSB  = 0;
  localparam int unsigned IMODE2_LSB  = 2;
  localparam logic [1:0]  IMODE_OFF   = 2'h0;
  localparam logic [1:0]  IMODE_C0    = 2'h1;
  localparam logic [1:0]  IMODE_C3C0  = 2'h2;
  localparam logic [1:0]  IMODE_ALT   = 2'h3;
  localparam logic [1:0]  MODE_RESET  = 2'h0;
  // counter zero modes; 2 and 3 reload at terminal count, 3 toggles its output
  localparam logic [2:0]  T0_RATE     = 3'h2;
  localparam logic [2:0]  T0_SQUARE   = 3'h3;
  localparam logic [2:0]  T0_LAST     = 3'h5;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  typedef struct packed {
    logic [2:0]  mode;
    logic [15:0] init;
  } dioc_t0_cmd_t;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } dioc_casc_div_t;
endpackage

// *** tb/dioc_pin_model.sv ***
// far-side i/o lines: resolves each pin from card enable, external driver and pull-up
`timescale 1ns/1ps
module dioc_pin_model #(
  parameter int unsigned NUM_CH = 4
) (
  input  wire logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_out,
  input  wire logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_oe,
  input  wire logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] ext_val,
  input  wire logic [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] ext_oe,
  output logic      [NUM_CH-1:0][dioc_pkg::PORT_W-1:0] pin_in
);
  // card wins where it drives; an undriven line is pulled high, never left at the last value
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
  end
endmodule

// *** tb/dioc_top_tb.sv ***
// self-checking bench for the digital i/o channel block
`timescale 1ns/1ps
module dioc_top_tb;
  localparam int unsigned NC = 4;
  logic                         clk, sys_rst, clk_en, soft_reset, cfg_wr, out_wr, int_ctrl_wr;
  logic                         ext_event_pin, irq_clr, t0_load, t0_stop, casc_start;
  logic [1:0]                   cfg_ch, out_ch;
  logic [3:0]                   control_code, int_ctrl;
  logic [23:0]                  out_data;
  logic [NC-1:0][23:0]          pin_in, pin_out, pin_oe, rd_data, ext_val, ext_oe;
  logic                         p1, p2, irq_out, t0_running, t0_out, casc_out;
  logic [15:0]                  t0_count, t0_held, v;
  dioc_pkg::dioc_t0_cmd_t       t0_cmd;
  dioc_pkg::dioc_casc_div_t     casc_div;
  int                           n_fail, n_tests, t1, t2;

  dioc_top #(.NUM_CH(NC)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .soft_reset(soft_reset),
    .cfg_wr(cfg_wr), .cfg_ch(cfg_ch), .control_code(control_code), .out_wr(out_wr), .out_ch(out_ch),
    .out_data(out_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .rd_data(rd_data),
    .int_ctrl_wr(int_ctrl_wr), .int_ctrl(int_ctrl), .ext_event_pin(ext_event_pin), .irq_clr(irq_clr),
    .first_source_pending(p1), .second_source_pending(p2), .irq_out(irq_out), .t0_load(t0_load),
    .t0_cmd(t0_cmd), .t0_stop(t0_stop), .t0_count(t0_count), .t0_held(t0_held), .t0_running(t0_running),
    .t0_out(t0_out), .casc_start(casc_start), .casc_div(casc_div), .casc_out(casc_out));
  dioc_pin_model #(.NUM_CH(NC)) pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wide enough for a whole pin bus of all channels
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cfg(input logic [1:0] ch, input logic [3:0] code);
    cfg_ch = ch; control_code = code; cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(2);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  // a zero direction bit drives its group; 1 leaves it an input
  function automatic logic [23:0] oe_of(input logic [3:0] c);
    return {{4{~c[2]}}, {4{~c[0]}}, {8{~c[1]}}, {8{~c[3]}}};
  endfunction

  task automatic irq_case(input logic [3:0] mode, input int src, input logic exp);
    int_ctrl = mode;
    pulse(int_ctrl_wr);
    pulse(irq_clr);
    // src 3 raises bits 19 and 16 of channel zero together
    if (src == 2) ext_event_pin = 1'b1;
    else if (src == 3) ext_val[0][19:16] = 4'h9;
    else ext_val[src][16] = 1'b1;
    tick(6);
    chk({p2, p1}, exp ? (src == 1 ? 2'h2 : 2'h1) : 2'h0, "pending set");
    tick(20);
    chk(irq_out, exp, "pending held");
    pulse(irq_clr);
    tick(1);
    chk({irq_out, p2, p1}, 3'h0, "pending clear");
    ext_val = '0; ext_event_pin = 1'b0;
    tick(6);
  endtask

  task automatic print_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #250000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    print_verdict;
  end

  initial begin
    {sys_rst, clk_en} = 2'h3;
    {soft_reset, cfg_wr, out_wr, int_ctrl_wr, ext_event_pin, irq_clr, t0_load, t0_stop, casc_start} = '0;
    {cfg_ch, out_ch, control_code, int_ctrl, out_data} = '0;
    t0_cmd = '0; casc_div = '0; ext_val = '0; ext_oe = '1;
    tick(16);
    sys_rst = 1'b0;
    chk(pin_oe, '0, "reset dir");
    for (int c = 0; c < 16; c++) begin
      cfg(2'h0, c[3:0]);
      chk(pin_oe[0], oe_of(c[3:0]), "dir code");
    end
    $display("test direction done");
    cfg(2'h1, 4'h0);
    out_ch = 2'h1; out_data = 24'hA5C35A;
    pulse(out_wr);
    tick(4);
    chk(rd_data[1], 24'hA5C35A, "loopback");
    for (int c = 0; c < NC; c++) cfg(c[1:0], 4'h0);
    pulse(soft_reset);
    tick(2);
    chk(pin_oe, '0, "soft reset dir");
    chk(pin_out[1], 24'hA5C35A, "soft reset keeps latch");
    $display("test soft reset done");
    irq_case(4'h0, 0, 1'b0);
    irq_case(4'h1, 0, 1'b1);
    irq_case(4'h4, 1, 1'b1);
    irq_case(4'h3, 2, 1'b1);
    irq_case(4'h8, 2, 1'b0);
    irq_case(4'h2, 3, 1'b1);
    irq_case(4'h2, 0, 1'b0);
    $display("test interrupt done");
    for (int m = 0; m < 6; m++) begin
      t0_cmd = '{mode: m[2:0], init: 16'h0100 + 16'(m)};
      pulse(t0_load);
      chk({t0_running, t0_count}, {1'b1, 16'h00FF + 16'(m)}, "t0 start");
      tick(10);
      chk(t0_count, 16'h00F5 + 16'(m), "t0 live");
      pulse(t0_stop);
      tick(5);
      chk({t0_running, t0_held, t0_count}, {1'b0, 16'h00F5 + 16'(m), 16'h00F5 + 16'(m)}, "t0 stop");
    end
    t0_cmd = '{mode: 3'h1, init: 16'h0003};
    pulse(t0_load);
    tick(8);
    chk({t0_running, t0_out, t0_count}, {1'b0, 1'b1, 16'h0000}, "t0 one-shot end");
    $display("test counter zero done");
    int_ctrl = 4'hC;
    pulse(int_ctrl_wr);
    casc_div = '{first: 16'h0003, second: 16'h0002};
    pulse(casc_start);
    for (int k = 0; k < 3; k++) begin
      v[0] = casc_out;
      t1 = 0;
      while (casc_out === v[0] && t1 < 50) begin
        tick(1);
        t1++;
      end
      if (k == 2) chk(24'(t1), 24'd6, "cascade period");
    end
    chk({p2, p1}, 2'h2, "timer source pending");
    $display("test cascade done");
    print_verdict;
  end
endmodule
